// ===== rtl/atr_regs.sv
// Antenna tuning and AM depth register bank behind an APB slave
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
//
// Function
// - The converter result register shows the last completed 8-bit conversion.
// - Read-only display registers clear to zero at reset and on set-default.
// - With trim source 0 the trim switches follow the automatic tuning code.
// - With trim source 1 the trim switches follow the four manual trim bits.
// - Each applied trim bit at 1 turns on its transistor in both pin groups.
// - The phase target register feeds tuning and resets to only bit 7 set.
// - The tuning code found is stored in bits 7..4 of the tuning display.
// - The tuning error flag sits in bit 3 of the tuning display register.
// - With AM source 0 the modulated level comes from the 6-bit depth code.
// - With AM source 1 the modulated level comes from the manual mask.
// - Mask bits at 1 disable segments when modulated, only with source 1.
////////////////////////////////////////////////////////////////////////////////
module atr_regs (
  input  wire logic               clk,            // 200 MHz clock
  input  wire logic               nrst,           // Async reset, active low
  input  wire logic               psel,           // APB select
  input  wire logic               penable,        // APB access phase
  input  wire logic               pwrite,         // APB write
  input  wire logic [11:0]        paddr,          // APB byte address
  input  wire logic [31:0]        pwdata,         // APB write data
  output logic                    pready,         // APB ready
  output logic [31:0]             prdata,         // APB read data
  output logic                    pslverr,        // APB error
  input  wire logic               set_default,    // Set-default command pulse
  input  wire logic               conv_done,      // Conversion finished pulse
  input  wire logic [7:0]         conv_value,     // Conversion value
  input  wire logic               depth_cal_done, // Depth calibration pulse
  input  wire logic [5:0]         depth_cal_code, // Calibrated depth code
  input  wire atr_pkg::atr_tune_res_t tune_res,   // Automatic tuning result
  output logic [7:0]              phase_goal_bits,      // Tuning target phase
  output logic [3:0]              trim_pin_group_one,   // Trim transistors 1
  output logic [3:0]              trim_pin_group_two,   // Trim transistors 2
  output atr_pkg::atr_drive_t     drive,                // Driver settings
  output logic [7:0]              manual_am_segment_mask // Mask as stored
);

  logic [7:0] conv_result;
  logic [7:0] tune_ctrl;
  logic [7:0] phase_target;
  logic [7:0] tune_result;
  logic [7:0] am_depth;
  logic [7:0] am_segment;
  logic [7:0] next_conv_result;
  logic [7:0] next_tune_ctrl;
  logic [7:0] next_phase_target;
  logic [7:0] next_tune_result;
  logic [7:0] next_am_depth;
  logic [7:0] next_am_segment;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        wr_en;
  logic        rd_en;
  logic [9:0]  word_idx;
  logic        addr_ok;
  logic        mapped;
  logic [7:0]  rd_byte;
  logic [3:0]  next_trim;
  atr_pkg::atr_drive_t next_drive;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: zero-wait slave, answers in the setup cycle's access phase
  assign pready   = 1'b1;
  assign word_idx = paddr[11:2];
  assign addr_ok  = (paddr[1:0] == 2'h0) && (word_idx[9:8] == 2'h0);
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;

  // Read mux; unmapped words read zero and raise pslverr
  always_comb begin
    rd_byte = 8'h00;
    mapped  = addr_ok;
    case (word_idx[7:0])
      atr_pkg::IDX_CONV_RESULT:  rd_byte = conv_result;
      atr_pkg::IDX_TUNE_CTRL:    rd_byte = tune_ctrl;
      atr_pkg::IDX_PHASE_TARGET: rd_byte = phase_target;
      atr_pkg::IDX_TUNE_RESULT:  rd_byte = tune_result;
      atr_pkg::IDX_AM_DEPTH:     rd_byte = am_depth;
      atr_pkg::IDX_AM_SEGMENT:   rd_byte = am_segment;
      default:                   mapped  = 1'b0;
    endcase
    if (!addr_ok) begin
      rd_byte = 8'h00;
    end
  end

  // Read data registered at setup so it stands through the access phase
  always_comb begin
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (rd_en) begin
      next_prdata = {24'h000000, rd_byte};
    end
    if (psel && !penable) begin
      next_pslverr = !mapped;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register next values; set-default wins over any write or hardware update
  always_comb begin
    next_conv_result  = conv_result;
    next_tune_ctrl    = tune_ctrl;
    next_phase_target = phase_target;
    next_tune_result  = tune_result;
    next_am_depth     = am_depth;
    next_am_segment   = am_segment;
    if (conv_done) begin
      next_conv_result = conv_value;
    end
    if (tune_res.valid) begin
      next_tune_result = {tune_res.code, tune_res.err, 3'h0};
    end
    if (wr_en && addr_ok) begin
      case (word_idx[7:0])
        atr_pkg::IDX_TUNE_CTRL:
          next_tune_ctrl = {pwdata[7:3], 3'h0};
        atr_pkg::IDX_PHASE_TARGET:
          next_phase_target = pwdata[7:0];
        atr_pkg::IDX_AM_DEPTH:
          next_am_depth = {pwdata[7:1], 1'b0};
        atr_pkg::IDX_AM_SEGMENT:
          next_am_segment = pwdata[7:0];
        default: begin
        end
      endcase
    end
    // Calibration overrides the code field but keeps the source bit
    if (depth_cal_done) begin
      next_am_depth[atr_pkg::DEPTH_CODE_MSB:atr_pkg::DEPTH_CODE_LSB] =
        depth_cal_code;
    end
    if (set_default) begin
      next_conv_result  = atr_pkg::RST_ZERO;
      next_tune_result  = atr_pkg::RST_ZERO;
      next_tune_ctrl    = atr_pkg::RST_ZERO;
      next_phase_target = atr_pkg::RST_PHASE_TARGET;
      next_am_depth     = atr_pkg::RST_ZERO;
      next_am_segment   = atr_pkg::RST_ZERO;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conv_result  <= atr_pkg::RST_ZERO;
      tune_ctrl    <= atr_pkg::RST_ZERO;
      phase_target <= atr_pkg::RST_PHASE_TARGET;
      tune_result  <= atr_pkg::RST_ZERO;
      am_depth     <= atr_pkg::RST_ZERO;
      am_segment   <= atr_pkg::RST_ZERO;
    end else begin
      conv_result  <= next_conv_result;
      tune_ctrl    <= next_tune_ctrl;
      phase_target <= next_phase_target;
      tune_result  <= next_tune_result;
      am_depth     <= next_am_depth;
      am_segment   <= next_am_segment;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive outputs are flops loaded from the next register values, so they
  // move on the same edge as the registers and never glitch at the pins
  always_comb begin
    if (next_tune_ctrl[atr_pkg::TRIM_SRC_BIT]) begin
      next_trim =
        next_tune_ctrl[atr_pkg::TRIM_CODE_MSB:atr_pkg::TRIM_CODE_LSB];
    end else begin
      next_trim = next_tune_result[7:4];
    end
    next_drive.trim       = next_trim;
    next_drive.am_src     = next_am_depth[atr_pkg::AM_SRC_BIT];
    next_drive.depth_code =
      next_am_depth[atr_pkg::DEPTH_CODE_MSB:atr_pkg::DEPTH_CODE_LSB];
    // Segment mask only reaches the drivers with the manual source selected
    if (next_am_depth[atr_pkg::AM_SRC_BIT]) begin
      next_drive.segment_off = next_am_segment;
    end else begin
      next_drive.segment_off = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drive <= '{trim: 4'h0, am_src: 1'b0, depth_code: 6'h00,
                 segment_off: atr_pkg::RST_ZERO};
    end else begin
      drive <= next_drive;
    end
  end

  assign trim_pin_group_one = drive.trim;
  assign trim_pin_group_two = drive.trim;
  assign phase_goal_bits    = phase_target;
  assign manual_am_segment_mask = am_segment;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_conv_capture;
    @(posedge clk) disable iff (!nrst)
    (conv_done && !set_default) |=> (conv_result == $past(conv_value));
  endproperty
  a_conv_capture: assert property (p_conv_capture)
    else $error("conversion result not captured");

  property p_default_clears;
    @(posedge clk) disable iff (!nrst)
    set_default |=> (conv_result == 8'h00 && tune_result == 8'h00);
  endproperty
  a_default_clears: assert property (p_default_clears)
    else $error("display registers not cleared");

  property p_trim_auto;
    @(posedge clk) disable iff (!nrst)
    !tune_ctrl[7] |-> (trim_pin_group_one == tune_result[7:4]);
  endproperty
  a_trim_auto: assert property (p_trim_auto)
    else $error("trim not from tuning result");

  property p_trim_manual;
    @(posedge clk) disable iff (!nrst)
    tune_ctrl[7] |-> (trim_pin_group_one == tune_ctrl[6:3]);
  endproperty
  a_trim_manual: assert property (p_trim_manual)
    else $error("trim not from manual bits");

  property p_trim_groups;
    @(posedge clk) disable iff (!nrst)
    trim_pin_group_one == trim_pin_group_two;
  endproperty
  a_trim_groups: assert property (p_trim_groups)
    else $error("trim groups differ");

  sequence s_phase_write;
    wr_en && addr_ok && word_idx == 10'h022 && !set_default;
  endsequence
  property p_phase_write;
    @(posedge clk) disable iff (!nrst)
    s_phase_write |=> (phase_goal_bits == $past(pwdata[7:0]));
  endproperty
  a_phase_write: assert property (p_phase_write)
    else $error("phase target not written");

  property p_tune_store;
    @(posedge clk) disable iff (!nrst)
    (tune_res.valid && !set_default) |=>
      (tune_result[7:4] == $past(tune_res.code));
  endproperty
  a_tune_store: assert property (p_tune_store)
    else $error("tuning code not stored");

  property p_tune_err;
    @(posedge clk) disable iff (!nrst)
    (tune_res.valid && !set_default) |=>
      (tune_result[3] == $past(tune_res.err));
  endproperty
  a_tune_err: assert property (p_tune_err)
    else $error("tuning error flag wrong");

  property p_am_depth;
    @(posedge clk) disable iff (!nrst)
    (!am_depth[7]) |-> (drive.segment_off == 8'h00 && !drive.am_src &&
                        drive.depth_code == am_depth[6:1]);
  endproperty
  a_am_depth: assert property (p_am_depth)
    else $error("mask applied with depth source");

  property p_am_manual;
    @(posedge clk) disable iff (!nrst)
    am_depth[7] |-> (drive.segment_off == am_segment);
  endproperty
  a_am_manual: assert property (p_am_manual)
    else $error("manual mask not applied");

  property p_unused_zero;
    @(posedge clk) disable iff (!nrst)
    (tune_ctrl[2:0] == 3'h0) && (tune_result[2:0] == 3'h0) &&
    (am_depth[0] == 1'b0) && (prdata[31:8] == 24'h000000);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bits not zero");

  // Calibration must reach the driver code even without a software write
  property p_depth_cal;
    @(posedge clk) disable iff (!nrst)
    (depth_cal_done && !set_default) |=>
      (drive.depth_code == $past(depth_cal_code));
  endproperty
  a_depth_cal: assert property (p_depth_cal)
    else $error("calibrated depth code not applied");

  property p_am_source;
    @(posedge clk) disable iff (!nrst)
    drive.am_src == am_depth[atr_pkg::AM_SRC_BIT];
  endproperty
  a_am_source: assert property (p_am_source)
    else $error("AM level source not applied");

endmodule
`default_nettype wire

// ===== shared/atr_pkg.sv
// Package: register map, field layout and reset values of the tuning bank
`default_nettype none
package atr_pkg;

  // Printed offsets are not multiples of four: these are word indices
  localparam logic [7:0] IDX_CONV_RESULT  = 8'h20;
  localparam logic [7:0] IDX_TUNE_CTRL    = 8'h21;
  localparam logic [7:0] IDX_PHASE_TARGET = 8'h22;
  localparam logic [7:0] IDX_TUNE_RESULT  = 8'h23;
  localparam logic [7:0] IDX_AM_DEPTH     = 8'h24;
  localparam logic [7:0] IDX_AM_SEGMENT   = 8'h26;

  // Field positions
  localparam int TRIM_SRC_BIT   = 7;
  localparam int TRIM_CODE_MSB  = 6;
  localparam int TRIM_CODE_LSB  = 3;
  localparam int TUNE_ERR_BIT   = 3;
  localparam int AM_SRC_BIT     = 7;
  localparam int DEPTH_CODE_MSB = 6;
  localparam int DEPTH_CODE_LSB = 1;

  // Reset values
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_PHASE_TARGET = 8'h80;

  // Automatic tuning result as handed over by the tuning engine
  typedef struct packed {
    logic       valid;  // One-cycle pulse: store code and error
    logic [3:0] code;   // Trim code found
    logic       err;    // Resonance not reached
  } atr_tune_res_t;

  // Drive settings handed to the analogue front end
  typedef struct packed {
    logic [3:0] trim;         // Applied trim bits, MSB first
    logic       am_src;       // 1: manual segment mask in use
    logic [5:0] depth_code;   // Calibrated depth code
    logic [7:0] segment_off;  // Segments disabled while AM modulated
  } atr_drive_t;

endpackage
`default_nettype wire

// ===== testbench/atr_host.sv
// APB host model that issues register accesses to the tuning bank
`timescale 1ns/1ps
`default_nettype none
module atr_host (
  input  wire logic        clk,     // Bus clock
  output logic             psel,    // Select
  output logic             penable, // Access phase
  output logic             pwrite,  // Direction
  output logic [11:0]      paddr,   // Byte address
  output logic [31:0]      pwdata,  // Write data
  input  wire logic        pready,  // Ready
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pslverr  // Error response
);
  // Bus idle from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end
  // One transfer; the request stays put until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_antenna_tuning_am_depth_regs.sv
// Self-checking bench for the antenna tuning and AM depth bank
`timescale 1ns/1ps
`default_nettype none
module tb_antenna_tuning_am_depth_regs;
  logic                   clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata;
  logic                   set_default, conv_done, depth_cal_done;
  logic [7:0]             conv_value, phase_goal_bits, manual_am_segment_mask;
  logic [5:0]             depth_cal_code;
  logic [3:0]             trim_pin_group_one, trim_pin_group_two;
  atr_pkg::atr_tune_res_t tune_res;
  atr_pkg::atr_drive_t    drive;
  int                     mismatches = 0;
  int                     total_checks = 0;
  logic [7:0]             idxs [6] =
    '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h26};
  logic [7:0]             rsts [6] =
    '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};

  atr_host host_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));
  atr_regs dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .set_default(set_default),
    .conv_done(conv_done), .conv_value(conv_value),
    .depth_cal_done(depth_cal_done), .depth_cal_code(depth_cal_code),
    .tune_res(tune_res), .phase_goal_bits(phase_goal_bits),
    .trim_pin_group_one(trim_pin_group_one),
    .trim_pin_group_two(trim_pin_group_two), .drive(drive),
    .manual_am_segment_mask(manual_am_segment_mask));

  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Read one word and compare data and error response
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e,
                      input logic er);
    logic [31:0] q;
    logic        x;
    host_u.xfer(1'b0, idx, 8'h00, q, x);
    chk("read data", {24'h000000, e}, q);
    chk("read error", {31'h0, er}, {31'h0, x});
  endtask
  // Write, then wait half a cycle so outputs have settled
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic        x;
    host_u.xfer(1'b1, idx, d, q, x);
    @(negedge clk);
  endtask
  task automatic reset_map;
    for (int i = 0; i < 6; i++) rchk(idxs[i], rsts[i], 1'b0);
    rchk(8'h25, 8'h00, 1'b1);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the hundred-odd cycles the tests need
  initial begin
    #50000;
    mismatches++;
    conclude;
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    set_default = 1'b0;
    conv_done = 1'b0;
    conv_value = 8'h00;
    depth_cal_done = 1'b0;
    depth_cal_code = 6'h00;
    tune_res = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    reset_map;
    $display("test reset values done");
    // Manual trim: unused low bits dropped, code drives both groups
    wr(8'h21, 8'hFF);
    rchk(8'h21, 8'hF8, 1'b0);
    wr(8'h21, 8'h90);
    chk("trim one", 32'h2, {28'h0, trim_pin_group_one});
    chk("trim two", 32'h2, {28'h0, trim_pin_group_two});
    // Automatic result with error, then trim source back to automatic
    @(posedge clk);
    tune_res <= '{valid: 1'b1, code: 4'hA, err: 1'b1};
    @(posedge clk);
    tune_res <= '0;
    wr(8'h23, 8'h00);
    rchk(8'h23, 8'hA8, 1'b0);
    chk("trim src1", 32'h2, {28'h0, trim_pin_group_one});
    wr(8'h21, 8'h00);
    chk("trim auto", 32'hA, {28'h0, trim_pin_group_two});
    chk("drive trim", 32'hA, {28'h0, drive.trim});
    $display("test trim done");
    // Converter result, write to it ignored
    @(posedge clk);
    conv_done <= 1'b1;
    conv_value <= 8'h5A;
    @(posedge clk);
    conv_done <= 1'b0;
    wr(8'h20, 8'h00);
    rchk(8'h20, 8'h5A, 1'b0);
    wr(8'h22, 8'h3C);
    chk("phase goal", 32'h3C, {24'h0, phase_goal_bits});
    $display("test converter and phase done");
    // AM level source: manual mask, then calibrated code
    wr(8'h26, 8'hA5);
    wr(8'h24, 8'hFF);
    rchk(8'h24, 8'hFE, 1'b0);
    chk("seg on", 32'hA5, {24'h0, drive.segment_off});
    chk("src on", 32'h1, {31'h0, drive.am_src});
    wr(8'h24, 8'h54);
    chk("seg off", 32'h0, {24'h0, drive.segment_off});
    chk("depth", 32'h2A, {26'h0, drive.depth_code});
    chk("mask", 32'hA5, {24'h0, manual_am_segment_mask});
    @(posedge clk);
    depth_cal_done <= 1'b1;
    depth_cal_code <= 6'h15;
    @(posedge clk);
    depth_cal_done <= 1'b0;
    rchk(8'h24, 8'h2A, 1'b0);
    chk("cal depth", 32'h15, {26'h0, drive.depth_code});
    $display("test am level done");
    // Set-default restores every register
    @(posedge clk);
    set_default <= 1'b1;
    @(posedge clk);
    set_default <= 1'b0;
    reset_map;
    chk("phase reset", 32'h80, {24'h0, phase_goal_bits});
    $display("test set default done");
    conclude;
  end
endmodule
`default_nettype wire
